// >>> hw/umaf_filter.sv
// Receive-side multiprocessor address filter and interrupt mapping for two UARTs
// Contract
// - Separate rx/tx requests, ranks 7 to 10
// - Nine-bit modes capture ninth bit flag
// - Multiproc enable in modes 2/3 needs ninth bit one
// - Mode 0 ignores multiproc enable
// - Mode 1 enable requires valid stop
// - Modes 2/3 match given or broadcast
// - Only ninth-bit-one frames are address candidates
// - Given compare only where mask is one
// - Broadcast is value OR mask, zeros ignored
// - Reset clears address value and mask
// - All-zero value and mask match every ninth-bit-one frame
`timescale 1ns/1ps
module umaf_filter #(
  parameter int DEPTH = umaf_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] mode,
  input wire logic multiproc_enable,
  input wire logic addr_load,
  input wire logic [7:0] addr_value_in,
  input wire logic [7:0] addr_mask_in,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire umaf_pkg::umaf_frame_t frame_in,
  input wire logic rx_int_clear,
  input wire logic tx_done,
  input wire logic tx_int_clear,
  input wire logic uart_sel,
  output logic rx_int_flag,
  output logic tx_int_flag,
  output logic rx_ninth_bit,
  output logic framing_err_flag,
  output logic [7:0] rx_data,
  output logic [7:0] slave_addr_value,
  output logic [7:0] slave_addr_mask,
  output logic irq_rx,
  output logic irq_tx,
  output logic [3:0] irq_rx_rank,
  output logic [3:0] irq_tx_rank
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  umaf_pkg::umaf_frame_t buf_reg [DEPTH];
  logic [CNT_W-1:0] count_reg;
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W-1:0] wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_next;
  logic [CNT_W-1:0] count_next;
  logic [7:0] value_reg;
  logic [7:0] mask_reg;
  logic rx_flag_reg;
  logic tx_flag_reg;
  logic ninth_reg;
  logic fe_reg;
  logic [7:0] data_reg;
  logic uart_sel_reg;

  // Two-entry buffer; drained only while rx flag is clear, so it really fills
  wire push = frame_valid && frame_ready;
  wire head_valid = count_reg != '0;
  wire pop = head_valid && !rx_flag_reg;
  assign frame_ready = count_reg != CNT_FULL;
  // Pointers wrap at the last entry, so any depth works
  assign wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
  assign rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
  assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);
  umaf_pkg::umaf_frame_t head;
  assign head = buf_reg[rd_ptr_reg];

  // Address match
  wire [7:0] given_diff = (head.data ^ value_reg) & mask_reg;
  wire given_hit = given_diff == 8'h00;
  wire [7:0] bcast = value_reg | mask_reg;
  wire bcast_hit = (head.data & bcast) == bcast;
  wire nine_mode = mode == umaf_pkg::MODE_9BIT_FIX || mode == umaf_pkg::MODE_9BIT_VAR;
  wire addr_ok = head.ninth && (given_hit || bcast_hit);
  wire accept = (mode == umaf_pkg::MODE_SHIFT) ? 1'b1 :
                !multiproc_enable ? 1'b1 :
                (mode == umaf_pkg::MODE_8BIT) ? head.stop_ok :
                addr_ok;
  wire raise = pop && accept;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      value_reg <= umaf_pkg::ADDR_RESET;
      mask_reg <= umaf_pkg::ADDR_RESET;
      rx_flag_reg <= 1'b0;
      tx_flag_reg <= 1'b0;
      ninth_reg <= 1'b0;
      fe_reg <= 1'b0;
      data_reg <= 8'h00;
      uart_sel_reg <= 1'b0;
    end else begin
      if (push) begin
        buf_reg[wr_ptr_reg] <= frame_in;
        wr_ptr_reg <= wr_ptr_next;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_next;
      end
      count_reg <= count_next;
      if (addr_load) begin
        value_reg <= addr_value_in;
        mask_reg <= addr_mask_in;
      end
      rx_flag_reg <= raise || (rx_flag_reg && !rx_int_clear);
      tx_flag_reg <= tx_done || (tx_flag_reg && !tx_int_clear);
      if (raise) begin
        data_reg <= head.data;
        ninth_reg <= nine_mode ? head.ninth : head.stop_ok;
      end
      if (pop) begin
        fe_reg <= !head.stop_ok;
      end
      uart_sel_reg <= uart_sel;
    end
  end

  assign rx_int_flag = rx_flag_reg;
  assign tx_int_flag = tx_flag_reg;
  assign rx_ninth_bit = ninth_reg;
  assign framing_err_flag = fe_reg;
  assign rx_data = data_reg;
  assign slave_addr_value = value_reg;
  assign slave_addr_mask = mask_reg;
  assign irq_rx = rx_flag_reg;
  assign irq_tx = tx_flag_reg;
  assign irq_rx_rank = uart_sel_reg ? umaf_pkg::RANK_U1_RX : umaf_pkg::RANK_U0_RX;
  assign irq_tx_rank = uart_sel_reg ? umaf_pkg::RANK_U1_TX : umaf_pkg::RANK_U0_TX;

  // Steps of a frame through the filter
  sequence take_into_empty_s;
    push && count_reg == '0 && !rx_flag_reg;
  endsequence
  sequence shift_pop_s;
    pop && mode == umaf_pkg::MODE_SHIFT;
  endsequence
  sequence nine_pop_s;
    pop && nine_mode;
  endsequence
  sequence data_frame_s;
    pop && nine_mode && multiproc_enable && !head.ninth;
  endsequence
  sequence zero_addr_s;
    value_reg == umaf_pkg::ADDR_RESET && mask_reg == umaf_pkg::ADDR_RESET;
  endsequence

  data_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
    data_frame_s |=> !rx_int_flag)
    else $error("rx flag raised by data frame");
  mode0_a: assert property (@(posedge clk) disable iff (!reset_n)
    shift_pop_s |=> rx_int_flag)
    else $error("mode 0 frame filtered");
  stop_check_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop && mode == umaf_pkg::MODE_8BIT && multiproc_enable && !head.stop_ok |=> !rx_int_flag)
    else $error("mode 1 bad stop raised flag");
  addr_hit_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 head.ninth && head.data == value_reg |=> rx_int_flag && rx_ninth_bit)
    else $error("given address missed");
  mask_care_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop && nine_mode && multiproc_enable && ((head.data ^ value_reg) & mask_reg) != 8'h00
    && (head.data & (value_reg | mask_reg)) != (value_reg | mask_reg) |=> !rx_int_flag)
    else $error("masked mismatch accepted");
  bcast_hit_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 head.ninth && head.data == 8'hFF |=> rx_int_flag)
    else $error("broadcast missed");
  reset_clear_a: assert property (@(posedge clk)
    !reset_n |=> slave_addr_value == 8'h00 && slave_addr_mask == 8'h00)
    else $error("address not cleared by reset");
  rank_map_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq_tx_rank == irq_rx_rank + 4'h1 && irq_rx_rank == (uart_sel_reg ? 4'h9 : 4'h7))
    else $error("wrong arbitration ranks");
  flag_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_int_flag && !rx_int_clear |=> rx_int_flag)
    else $error("rx flag lost");
  lone_frame_a: assert property (@(posedge clk) disable iff (!reset_n)
    take_into_empty_s ##1 shift_pop_s |=> rx_int_flag && rx_data == $past(frame_in.data, 2))
    else $error("lone frame not delivered");
  ninth_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 !multiproc_enable |=> rx_int_flag && rx_ninth_bit == $past(head.ninth))
    else $error("ninth bit not captured");
  mode1_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop && mode == umaf_pkg::MODE_8BIT && head.stop_ok |=> rx_int_flag)
    else $error("mode 1 good stop filtered");
  frame_err_a: assert property (@(posedge clk) disable iff (!reset_n)
    pop |=> framing_err_flag == !$past(head.stop_ok))
    else $error("framing error flag wrong");
  zero_match_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 zero_addr_s ##0 head.ninth |=> rx_int_flag)
    else $error("cleared address filtered a frame");
  given_hit_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 head.ninth && (head.data & mask_reg) == (value_reg & mask_reg) |=> rx_int_flag)
    else $error("masked given address missed");
  bcast_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
    nine_pop_s ##0 head.ninth && (head.data | ~(value_reg | mask_reg)) == 8'hFF |=> rx_int_flag)
    else $error("masked broadcast missed");
  rx_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_int_flag && rx_int_clear |=> !rx_int_flag)
    else $error("rx flag not cleared");
  tx_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_done |=> tx_int_flag && irq_tx)
    else $error("tx request missing");
  tx_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_int_flag && tx_int_clear && !tx_done |=> !tx_int_flag)
    else $error("tx flag not cleared");
  addr_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    addr_load |=> slave_addr_value == $past(addr_value_in) && slave_addr_mask == $past(addr_mask_in))
    else $error("address registers not loaded");
  rank_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    uart_sel |=> irq_rx_rank == umaf_pkg::RANK_U1_RX && irq_tx_rank == umaf_pkg::RANK_U1_TX)
    else $error("second uart ranks wrong");
endmodule

// >>> shared/umaf_pkg.sv
// Package for the multiprocessor receive filter: modes, frame carrier, ranks, reset values
package umaf_pkg;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8BIT = 2'h1;
  localparam logic [1:0] MODE_9BIT_FIX = 2'h2;
  localparam logic [1:0] MODE_9BIT_VAR = 2'h3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [3:0] RANK_U0_RX = 4'h7;
  localparam logic [3:0] RANK_U0_TX = 4'h8;
  localparam logic [3:0] RANK_U1_RX = 4'h9;
  localparam logic [3:0] RANK_U1_TX = 4'hA;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop_ok;
  } umaf_frame_t;
endpackage

// >>> verification/umaf_master.sv
// Remote master UART model handing received frames to the filter
`timescale 1ns/1ps
module umaf_master (
  input wire logic clk,
  input wire logic frame_ready,
  output logic frame_valid,
  output umaf_pkg::umaf_frame_t frame_in
);
  initial begin
    frame_valid = 1'h0;
    frame_in = '0;
  end
  // Address frames carry ninth=1, data frames ninth=0; given or broadcast address chosen by caller
  task automatic send(input logic [7:0] d, input logic nb, input logic sb);
    frame_valid = 1'h1;
    frame_in = '{d, nb, sb};
    do @(posedge clk); while (frame_ready !== 1'h1);
    #1 frame_valid = 1'h0;
    frame_in = ~frame_in;
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the multiprocessor receive filter
`timescale 1ns/1ps
module testbench;
  logic clk, reset_n, multiproc_enable, addr_load, frame_valid, frame_ready, rx_int_clear, tx_done, tx_int_clear;
  logic uart_sel, rx_int_flag, tx_int_flag, rx_ninth_bit, framing_err_flag, irq_rx, irq_tx;
  logic [1:0] mode;
  logic [7:0] addr_value_in, addr_mask_in, rx_data, slave_addr_value, slave_addr_mask;
  logic [3:0] irq_rx_rank, irq_tx_rank;
  umaf_pkg::umaf_frame_t frame_in;
  int num_errors = 0;
  int checks = 0;
  umaf_filter umaf_filter_i (.clk, .reset_n, .mode, .multiproc_enable, .addr_load, .addr_value_in, .addr_mask_in,
    .frame_valid, .frame_ready, .frame_in, .rx_int_clear, .tx_done, .tx_int_clear, .uart_sel, .rx_int_flag,
    .tx_int_flag, .rx_ninth_bit, .framing_err_flag, .rx_data, .slave_addr_value, .slave_addr_mask, .irq_rx,
    .irq_tx, .irq_rx_rank, .irq_tx_rank);
  umaf_master umaf_master_i (.clk, .frame_ready, .frame_valid, .frame_in);
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Sends one frame, checks the flag two cycles later, then clears it
  task automatic frame(input logic [7:0] d, input logic nb, input logic exp_flag);
    umaf_master_i.send(d, nb, 1'h1);
    tick(2);
    check({6'h00, irq_rx, rx_int_flag}, {6'h00, exp_flag, exp_flag});
    if (exp_flag) check(rx_data, d);
    if (exp_flag && mode[1]) check({7'h00, rx_ninth_bit}, {7'h00, nb});
    rx_int_clear = 1'h1;
    tick(1);
    rx_int_clear = 1'h0;
  endtask
  task automatic addr_scenario;
    check(slave_addr_value | slave_addr_mask, 8'h00);
    mode = umaf_pkg::MODE_9BIT_VAR;
    multiproc_enable = 1'h1;
    frame(8'h5A, 1'h1, 1'h1);
    frame(8'h5A, 1'h0, 1'h0);
    addr_value_in = 8'hC0;
    addr_mask_in = 8'hFD;
    addr_load = 1'h1;
    tick(1);
    addr_load = 1'h0;
    check(slave_addr_value, 8'hC0);
    check(slave_addr_mask, 8'hFD);
    mode = umaf_pkg::MODE_9BIT_FIX;
    frame(8'hC2, 1'h1, 1'h1);
    frame(8'hC1, 1'h1, 1'h0);
    frame(8'hFF, 1'h1, 1'h1);
    frame(8'hC0, 1'h0, 1'h0);
    mode = umaf_pkg::MODE_SHIFT;
    frame(8'h33, 1'h0, 1'h1);
  endtask
  task automatic mode1_and_buffer;
    mode = umaf_pkg::MODE_8BIT;
    umaf_master_i.send(8'h44, 1'h0, 1'h0);
    tick(2);
    check({7'h00, rx_int_flag}, 8'h00);
    check({7'h00, framing_err_flag}, 8'h01);
    frame(8'h45, 1'h0, 1'h1);
    check({7'h00, framing_err_flag}, 8'h00);
    mode = umaf_pkg::MODE_9BIT_VAR;
    multiproc_enable = 1'h0;
    umaf_master_i.send(8'h12, 1'h1, 1'h1);
    tick(2);
    check({7'h00, rx_ninth_bit}, 8'h01);
    umaf_master_i.send(8'hA1, 1'h0, 1'h1);
    tick(1);
    umaf_master_i.send(8'hA2, 1'h0, 1'h1);
    check({7'h00, frame_ready}, 8'h00);
    rx_int_clear = 1'h1;
    tick(1);
    rx_int_clear = 1'h0;
    tick(2);
    check(rx_data, 8'hA1);
    check({7'h00, rx_ninth_bit}, 8'h00);
  endtask
  task automatic rank_scenario;
    check({irq_tx_rank, irq_rx_rank}, {umaf_pkg::RANK_U0_TX, umaf_pkg::RANK_U0_RX});
    uart_sel = 1'h1;
    tx_done = 1'h1;
    tick(1);
    tx_done = 1'h0;
    check({2'h0, irq_tx, tx_int_flag, irq_tx_rank}, {4'h3, umaf_pkg::RANK_U1_TX});
    check({3'h0, irq_rx, irq_rx_rank}, {4'h0, umaf_pkg::RANK_U1_RX});
    tx_int_clear = 1'h1;
    tick(1);
    check({6'h00, irq_tx, tx_int_flag}, 8'h00);
    tx_done = 1'h1;
    tick(1);
    tx_done = 1'h0;
    tx_int_clear = 1'h0;
    check({6'h00, irq_tx, tx_int_flag}, 8'h03);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {reset_n, mode, multiproc_enable, addr_load, rx_int_clear, tx_done, tx_int_clear, uart_sel} = '0;
    {addr_value_in, addr_mask_in} = '0;
    tick(20);
    reset_n = 1'h1;
    rank_scenario;
    addr_scenario;
    mode1_and_buffer;
    wrap_up;
  end
  initial begin
    #60000;
    num_errors++;
    wrap_up;
  end
endmodule
